// ### rtl/pci_pkg.sv
package pci_pkg;
  // ****************************************************************
  // bus geometry and encodings
  // ****************************************************************
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  // ****************************************************************
  // command register image
  // ****************************************************************
  localparam logic [7:0] CMD_REG_OFFSET = 8'h04;
  localparam int CMD_W = 16;
  localparam int PAR_RESP_POS = 6;
  localparam int SYS_ERR_POS = 8;
  // ****************************************************************
  // timing
  // ****************************************************************
  // clocks an initiator waits for a claim before a master abort
  localparam int DEVSEL_TIMEOUT = 5;
  localparam int CNT_W = 4;
  localparam logic STRAP_RST = 1'b1;
endpackage

// ### rtl/pci_if.sv
`timescale 1ns/1ps
interface pci_if;
  import pci_pkg::*;
  // ****************************************************************
  // resolved wire levels
  // ****************************************************************
  logic [AD_W-1:0] ad;
  logic [CBE_W-1:0] cbe;
  logic par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n;
  logic req_n, gnt_n, serr_n, pme;
  // ****************************************************************
  // device end drivers
  // ****************************************************************
  logic [AD_W-1:0] d_ad_o;
  logic [CBE_W-1:0] d_cbe_o;
  logic d_ad_oe_n, d_cbe_oe_n;
  logic d_par_o, d_frame_n_o, d_irdy_n_o, d_trdy_n_o, d_stop_n_o;
  logic d_devsel_n_o, d_perr_n_o, d_serr_n_o, d_pme_o;
  logic d_par_oe_n, d_frame_oe_n, d_irdy_oe_n, d_trdy_oe_n, d_stop_oe_n;
  logic d_devsel_oe_n, d_perr_oe_n, d_serr_oe_n, d_pme_oe_n;
  logic d_req_n_o;
  // ****************************************************************
  // host end drivers
  // ****************************************************************
  logic [AD_W-1:0] h_ad_o;
  logic [CBE_W-1:0] h_cbe_o;
  logic h_ad_oe_n, h_cbe_oe_n;
  logic h_par_o, h_frame_n_o, h_irdy_n_o, h_trdy_n_o, h_stop_n_o;
  logic h_devsel_n_o;
  logic h_par_oe_n, h_frame_oe_n, h_irdy_oe_n, h_trdy_oe_n, h_stop_oe_n;
  logic h_devsel_oe_n;
  logic h_gnt_n_o;

  // undriven lines float high through the pullups
  function automatic logic rs(input logic dv, input logic de,
                              input logic hv, input logic he);
    rs = !de ? dv : (!he ? hv : 1'b1);
  endfunction

  assign ad = !d_ad_oe_n ? d_ad_o : (!h_ad_oe_n ? h_ad_o : '1);
  assign cbe = !d_cbe_oe_n ? d_cbe_o : (!h_cbe_oe_n ? h_cbe_o : '1);
  assign par = rs(d_par_o, d_par_oe_n, h_par_o, h_par_oe_n);
  assign frame_n = rs(d_frame_n_o, d_frame_oe_n, h_frame_n_o, h_frame_oe_n);
  assign irdy_n = rs(d_irdy_n_o, d_irdy_oe_n, h_irdy_n_o, h_irdy_oe_n);
  assign trdy_n = rs(d_trdy_n_o, d_trdy_oe_n, h_trdy_n_o, h_trdy_oe_n);
  assign stop_n = rs(d_stop_n_o, d_stop_oe_n, h_stop_n_o, h_stop_oe_n);
  assign devsel_n = rs(d_devsel_n_o, d_devsel_oe_n, h_devsel_n_o,
                       h_devsel_oe_n);
  assign perr_n = !d_perr_oe_n ? d_perr_n_o : 1'b1;
  assign serr_n = !d_serr_oe_n ? d_serr_n_o : 1'b1;
  assign pme = !d_pme_oe_n ? d_pme_o : 1'b1;
  assign req_n = d_req_n_o;
  assign gnt_n = h_gnt_n_o;

  modport dev (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, gnt_n,
    output d_ad_o, d_cbe_o, d_ad_oe_n, d_cbe_oe_n, d_par_o, d_frame_n_o,
    d_irdy_n_o, d_trdy_n_o, d_stop_n_o, d_devsel_n_o, d_perr_n_o,
    d_serr_n_o, d_pme_o, d_par_oe_n, d_frame_oe_n, d_irdy_oe_n,
    d_trdy_oe_n, d_stop_oe_n, d_devsel_oe_n, d_perr_oe_n, d_serr_oe_n,
    d_pme_oe_n, d_req_n_o
  );
  modport host (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n,
    input perr_n, serr_n, pme, req_n,
    output h_ad_o, h_cbe_o, h_ad_oe_n, h_cbe_oe_n, h_par_o, h_frame_n_o,
    h_irdy_n_o, h_trdy_n_o, h_stop_n_o, h_devsel_n_o, h_par_oe_n,
    h_frame_oe_n, h_irdy_oe_n, h_trdy_oe_n, h_stop_oe_n, h_devsel_oe_n,
    h_gnt_n_o
  );
endinterface

// ### rtl/pci_dev_end.sv
// Summary of operation
// - data phase ends on edge with both readies
// - initiator drives its ready to complete phase
// - target drives its ready to complete phase
// - even parity over address/data and command lines
// - initiator drives parity one clock after data
// - target compares received parity, flags mismatch
// - parity error driven only when response enabled
// - address parity error pulses system error when enabled
// - system error reported even for unclaimed cycles
// - request bus, master only after grant
// - arbiter asserts grant to give bus ownership
// - target stop ends transaction; initiator obeys
// - power event output signals wake to host
// - strap low: output becomes active-high status change
// - frame held while continuing; release marks last phase
// - no claim before timeout: master abort
`timescale 1ns/1ps
module pci_dev_end
  import pci_pkg::*;
#(
  parameter logic [AD_W-1:0] BASE_ADDR = 32'h0001_0000,
  parameter int WIN_BITS = 12,
  parameter int TIMEOUT = DEVSEL_TIMEOUT
) (
  input wire logic mclk_i, // bus clock
  input wire logic rst_i, // sync reset, high
  pci_if.dev bus, // bus pins
  input wire logic [CMD_W-1:0] command_word_i, // command register image
  input wire logic pc_card_select_strap_i, // card strap, low = card
  input wire logic wake_i, // wake event level
  input wire logic m_start_i, // start master cycle
  input wire logic m_write_i, // master cycle is write
  input wire logic [AD_W-1:0] m_addr_i, // master address
  input wire logic [AD_W-1:0] m_wdata_i, // master write data
  input wire logic [CBE_W-1:0] m_be_i, // master byte enables, low
  output logic m_busy_o, // master request pending
  output logic m_done_o, // master data moved
  output logic m_abort_o, // master abort
  output logic m_stopped_o, // target stopped, no data
  output logic [AD_W-1:0] m_rdata_o, // master read data
  output logic t_wr_o, // target write taken
  output logic t_rd_o, // target read served
  output logic [AD_W-1:0] t_addr_o, // target address
  output logic [AD_W-1:0] t_wdata_o, // target write data
  output logic [CBE_W-1:0] t_be_o, // target byte enables
  input wire logic [AD_W-1:0] t_rdata_i, // target read data
  input wire logic clear_status_i, // clear error status
  output logic parity_error_seen_o, // sticky parity error
  output logic system_error_signaled_o // sticky system error
);
  // ****************************************************************
  // state and decode
  // ****************************************************************
  typedef enum logic [2:0] {S_IDLE, S_M_ADDR, S_M_DATA, S_M_TURN,
                            S_T_DATA, S_T_STOP, S_T_TURN} state_t;
  state_t state_r, state_nxt;
  logic pend_r, m_wr_r, t_wr_q_r, t_rdy_r, frame_q_r;
  logic [AD_W-1:0] m_addr_r, m_wdata_r, t_rd_q_r;
  logic [CBE_W-1:0] m_be_r;
  logic [CNT_W-1:0] cnt_r;
  logic calc_r, par_oe_n_r, addr_chk_r, dat_chk_r;
  logic perr_r, perr_q_r, serr_r, strap_r, strap_done_r, wake_r;
  logic bus_idle, xfer, m_go, t_start, hit, dpe, ape, timeout;
  logic perr_en, serr_en;

  assign perr_en = command_word_i[PAR_RESP_POS];
  assign serr_en = command_word_i[SYS_ERR_POS];
  assign bus_idle = bus.frame_n & bus.irdy_n;
  assign xfer = !bus.irdy_n & !bus.trdy_n;
  assign m_go = (state_r == S_IDLE) & pend_r & !bus.gnt_n &
                bus_idle;
  assign t_start = (state_r == S_IDLE) & !bus.frame_n & frame_q_r;
  assign hit = (bus.ad[AD_W-1:WIN_BITS] == BASE_ADDR[AD_W-1:WIN_BITS]) &
               ((bus.cbe == CMD_MEM_RD) | (bus.cbe == CMD_MEM_WR));
  assign timeout = bus.devsel_n & (cnt_r == CNT_W'(TIMEOUT - 1));
  assign m_busy_o = pend_r | (state_r == S_M_ADDR) | (state_r == S_M_DATA);
  assign bus.d_req_n_o = !pend_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (m_go) begin
          state_nxt = S_M_ADDR;
        end else if (t_start & hit) begin
          state_nxt = S_T_DATA;
        end
      end
      S_M_ADDR: state_nxt = S_M_DATA;
      S_M_DATA: begin
        if (xfer | !bus.stop_n | timeout) begin
          state_nxt = S_M_TURN;
        end
      end
      S_M_TURN: state_nxt = S_IDLE;
      S_T_DATA: begin
        if (xfer) begin
          state_nxt = bus.frame_n ? S_T_TURN : S_T_STOP;
        end else if (bus_idle) begin
          state_nxt = S_T_TURN;
        end
      end
      S_T_STOP: begin
        if (bus.frame_n) begin
          state_nxt = S_T_TURN;
        end
      end
      S_T_TURN: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      frame_q_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      frame_q_r <= bus.frame_n;
    end
  end

  // ****************************************************************
  // initiator side
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      m_wr_r <= 1'b0;
      m_addr_r <= '0;
      m_wdata_r <= '0;
      m_be_r <= '0;
    end else if (m_start_i & !m_busy_o) begin
      pend_r <= 1'b1;
      m_wr_r <= m_write_i;
      m_addr_r <= m_addr_i;
      m_wdata_r <= m_wdata_i;
      m_be_r <= m_be_i;
    end else if (m_go) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      m_done_o <= 1'b0;
      m_abort_o <= 1'b0;
      m_stopped_o <= 1'b0;
      m_rdata_o <= '0;
    end else begin
      m_done_o <= (state_r == S_M_DATA) & xfer;
      m_stopped_o <= (state_r == S_M_DATA) & !xfer & !bus.stop_n;
      m_abort_o <= (state_r == S_M_DATA) & !xfer & bus.stop_n & timeout;
      cnt_r <= (state_r == S_M_DATA) ? cnt_r + 1'b1 : '0;
      if ((state_r == S_M_DATA) & xfer & !m_wr_r) begin
        m_rdata_o <= bus.ad;
      end
    end
  end

  // ****************************************************************
  // target side
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      t_wr_q_r <= 1'b0;
      t_rdy_r <= 1'b0;
      t_rd_q_r <= '0;
      t_addr_o <= '0;
      t_wdata_o <= '0;
      t_be_o <= '0;
      t_wr_o <= 1'b0;
      t_rd_o <= 1'b0;
    end else begin
      t_wr_o <= (state_r == S_T_DATA) & xfer & t_wr_q_r;
      t_rd_o <= (state_r == S_T_DATA) & xfer & !t_wr_q_r;
      if (t_start & hit) begin
        t_addr_o <= bus.ad;
        t_wr_q_r <= (bus.cbe == CMD_MEM_WR);
        t_rdy_r <= 1'b0;
      end else if ((state_r == S_T_DATA) & !t_rdy_r) begin
        // one wait state lets the user answer from t_addr_o
        t_rdy_r <= 1'b1;
        t_rd_q_r <= t_rdata_i;
      end
      if ((state_r == S_T_DATA) & xfer) begin
        t_wdata_o <= bus.ad;
        t_be_o <= bus.cbe;
      end
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  always_comb begin
    bus.d_ad_o = '0;
    bus.d_ad_oe_n = 1'b1;
    bus.d_cbe_o = '0;
    bus.d_cbe_oe_n = 1'b1;
    bus.d_frame_n_o = 1'b1;
    bus.d_frame_oe_n = 1'b1;
    bus.d_irdy_n_o = 1'b1;
    bus.d_irdy_oe_n = 1'b1;
    bus.d_trdy_n_o = 1'b1;
    bus.d_trdy_oe_n = 1'b1;
    bus.d_stop_n_o = 1'b1;
    bus.d_stop_oe_n = 1'b1;
    bus.d_devsel_n_o = 1'b1;
    bus.d_devsel_oe_n = 1'b1;
    case (state_r)
      S_M_ADDR: begin
        bus.d_frame_n_o = 1'b0;
        bus.d_frame_oe_n = 1'b0;
        bus.d_ad_o = m_addr_r;
        bus.d_ad_oe_n = 1'b0;
        bus.d_cbe_o = m_wr_r ? CMD_MEM_WR : CMD_MEM_RD;
        bus.d_cbe_oe_n = 1'b0;
      end
      S_M_DATA: begin
        // single data phase, so frame is already released
        bus.d_frame_oe_n = 1'b0;
        bus.d_irdy_n_o = 1'b0;
        bus.d_irdy_oe_n = 1'b0;
        bus.d_cbe_o = m_be_r;
        bus.d_cbe_oe_n = 1'b0;
        bus.d_ad_o = m_wdata_r;
        bus.d_ad_oe_n = !m_wr_r;
      end
      S_M_TURN: bus.d_irdy_oe_n = 1'b0;
      S_T_DATA: begin
        bus.d_devsel_n_o = 1'b0;
        bus.d_devsel_oe_n = 1'b0;
        bus.d_trdy_n_o = !t_rdy_r;
        bus.d_trdy_oe_n = 1'b0;
        // burst attempt: disconnect with this data phase
        bus.d_stop_n_o = !(t_rdy_r & !bus.frame_n);
        bus.d_stop_oe_n = 1'b0;
        bus.d_ad_o = t_rd_q_r;
        bus.d_ad_oe_n = t_wr_q_r | !t_rdy_r;
      end
      S_T_STOP: begin
        bus.d_devsel_n_o = 1'b0;
        bus.d_devsel_oe_n = 1'b0;
        bus.d_trdy_oe_n = 1'b0;
        bus.d_stop_n_o = 1'b0;
        bus.d_stop_oe_n = 1'b0;
      end
      S_T_TURN: begin
        bus.d_devsel_oe_n = 1'b0;
        bus.d_trdy_oe_n = 1'b0;
        bus.d_stop_oe_n = 1'b0;
      end
      default: ;
    endcase
  end

  // ****************************************************************
  // parity and errors
  // ****************************************************************
  assign ape = addr_chk_r & (calc_r != bus.par);
  assign dpe = dat_chk_r & (calc_r != bus.par);
  assign bus.d_par_o = calc_r;
  assign bus.d_par_oe_n = par_oe_n_r;
  assign bus.d_perr_n_o = !perr_r;
  assign bus.d_perr_oe_n = !(perr_r | perr_q_r);
  assign bus.d_serr_n_o = 1'b0;
  assign bus.d_serr_oe_n = !serr_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      calc_r <= 1'b0;
      par_oe_n_r <= 1'b1;
      addr_chk_r <= 1'b0;
      dat_chk_r <= 1'b0;
      perr_r <= 1'b0;
      perr_q_r <= 1'b0;
      serr_r <= 1'b0;
    end else begin
      calc_r <= ^{bus.ad, bus.cbe};
      par_oe_n_r <= bus.d_ad_oe_n;
      addr_chk_r <= t_start;
      dat_chk_r <= xfer & (((state_r == S_T_DATA) & t_wr_q_r) |
                           ((state_r == S_M_DATA) & !m_wr_r));
      perr_r <= dpe & perr_en;
      perr_q_r <= perr_r;
      serr_r <= ape & serr_en;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      parity_error_seen_o <= 1'b0;
      system_error_signaled_o <= 1'b0;
    end else begin
      if (dpe | ape) begin
        parity_error_seen_o <= 1'b1;
      end else if (clear_status_i) begin
        parity_error_seen_o <= 1'b0;
      end
      if (serr_r) begin
        system_error_signaled_o <= 1'b1;
      end else if (clear_status_i) begin
        system_error_signaled_o <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // wake output and strap
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_r <= STRAP_RST;
      strap_done_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake_i;
      if (!strap_done_r) begin
        strap_r <= pc_card_select_strap_i;
        strap_done_r <= 1'b1;
      end
    end
  end

  assign bus.d_pme_o = !strap_r & wake_r;
  assign bus.d_pme_oe_n = strap_r ? !wake_r : 1'b0;
endmodule

// ### rtl/pci_host_end.sv
`timescale 1ns/1ps
module pci_host_end
  import pci_pkg::*;
#(
  parameter int TIMEOUT = DEVSEL_TIMEOUT
) (
  input wire logic mclk_i, // bus clock
  input wire logic rst_i, // sync reset, high
  pci_if.host bus, // bus pins
  input wire logic h_start_i, // start master cycle
  input wire logic h_write_i, // master cycle is write
  input wire logic [AD_W-1:0] h_addr_i, // master address
  input wire logic [AD_W-1:0] h_wdata_i, // master write data
  input wire logic [CBE_W-1:0] h_be_i, // master byte enables
  output logic h_busy_o, // master request pending
  output logic h_done_o, // master data moved
  output logic h_abort_o, // master abort
  output logic h_stopped_o, // target stopped, no data
  output logic [AD_W-1:0] h_rdata_o, // master read data
  input wire logic retry_i, // answer cycles with stop
  input wire logic par_flip_i, // drive inverted parity
  input wire logic [AD_W-1:0] t_rdata_i, // target read data
  output logic t_wr_o, // target write taken
  output logic [AD_W-1:0] t_addr_o, // target address
  output logic [AD_W-1:0] t_wdata_o // target write data
);
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_DATA, H_TURN,
                            H_T_DATA, H_T_STOP, H_T_TURN} hstate_t;
  hstate_t state_r, state_nxt;
  logic pend_r, wr_r, gnt_n_r, gnt_q_r, frame_q_r, retry_r, t_wr_q_r;
  logic par_r, par_oe_n_r;
  logic [AD_W-1:0] addr_r, wdata_r, t_rd_q_r;
  logic [CBE_W-1:0] be_r;
  logic [CNT_W-1:0] cnt_r;
  logic bus_idle, xfer, go, t_start, timeout;

  assign bus_idle = bus.frame_n & bus.irdy_n;
  assign xfer = !bus.irdy_n & !bus.trdy_n;
  // own the bus only after the grant has been off for two edges
  assign go = (state_r == H_IDLE) & pend_r & gnt_n_r & gnt_q_r & bus_idle;
  assign t_start = (state_r == H_IDLE) & !bus.frame_n & frame_q_r;
  assign timeout = bus.devsel_n & (cnt_r == CNT_W'(TIMEOUT - 1));
  assign h_busy_o = pend_r | (state_r == H_ADDR) | (state_r == H_DATA);
  assign bus.h_gnt_n_o = gnt_n_r;
  // inverted parity lets the far end's error paths be exercised
  assign bus.h_par_o = par_r ^ par_flip_i;
  assign bus.h_par_oe_n = par_oe_n_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      H_IDLE: begin
        if (go) begin
          state_nxt = H_ADDR;
        end else if (t_start) begin
          state_nxt = H_T_DATA;
        end
      end
      H_ADDR: state_nxt = H_DATA;
      H_DATA: if (xfer | !bus.stop_n | timeout) state_nxt = H_TURN;
      H_TURN: state_nxt = H_IDLE;
      H_T_DATA: begin
        if (retry_r | (xfer & !bus.frame_n)) begin
          state_nxt = H_T_STOP;
        end else if (xfer | bus_idle) begin
          state_nxt = H_T_TURN;
        end
      end
      H_T_STOP: if (bus.frame_n) state_nxt = H_T_TURN;
      H_T_TURN: state_nxt = H_IDLE;
      default: state_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= H_IDLE;
      frame_q_r <= 1'b1;
      gnt_n_r <= 1'b1;
      gnt_q_r <= 1'b1;
      par_r <= 1'b0;
      par_oe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      frame_q_r <= bus.frame_n;
      gnt_n_r <= !(!bus.req_n & !pend_r & (state_r == H_IDLE));
      gnt_q_r <= gnt_n_r;
      par_r <= ^{bus.ad, bus.cbe};
      par_oe_n_r <= bus.h_ad_oe_n;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      be_r <= '0;
    end else if (h_start_i & !h_busy_o) begin
      pend_r <= 1'b1;
      wr_r <= h_write_i;
      addr_r <= h_addr_i;
      wdata_r <= h_wdata_i;
      be_r <= h_be_i;
    end else if (go) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      h_done_o <= 1'b0;
      h_abort_o <= 1'b0;
      h_stopped_o <= 1'b0;
      h_rdata_o <= '0;
      retry_r <= 1'b0;
      t_wr_q_r <= 1'b0;
      t_rd_q_r <= '0;
      t_addr_o <= '0;
      t_wdata_o <= '0;
      t_wr_o <= 1'b0;
    end else begin
      h_done_o <= (state_r == H_DATA) & xfer;
      h_stopped_o <= (state_r == H_DATA) & !xfer & !bus.stop_n;
      h_abort_o <= (state_r == H_DATA) & !xfer & bus.stop_n & timeout;
      cnt_r <= (state_r == H_DATA) ? cnt_r + 1'b1 : '0;
      if ((state_r == H_DATA) & xfer & !wr_r) begin
        h_rdata_o <= bus.ad;
      end
      t_wr_o <= (state_r == H_T_DATA) & xfer & t_wr_q_r;
      if (t_start) begin
        t_addr_o <= bus.ad;
        t_wr_q_r <= (bus.cbe == CMD_MEM_WR);
        retry_r <= retry_i;
        t_rd_q_r <= t_rdata_i;
      end
      if ((state_r == H_T_DATA) & xfer) begin
        t_wdata_o <= bus.ad;
      end
    end
  end

  always_comb begin
    bus.h_ad_o = '0;
    bus.h_ad_oe_n = 1'b1;
    bus.h_cbe_o = '0;
    bus.h_cbe_oe_n = 1'b1;
    bus.h_frame_n_o = 1'b1;
    bus.h_frame_oe_n = 1'b1;
    bus.h_irdy_n_o = 1'b1;
    bus.h_irdy_oe_n = 1'b1;
    bus.h_trdy_n_o = 1'b1;
    bus.h_trdy_oe_n = 1'b1;
    bus.h_stop_n_o = 1'b1;
    bus.h_stop_oe_n = 1'b1;
    bus.h_devsel_n_o = 1'b1;
    bus.h_devsel_oe_n = 1'b1;
    case (state_r)
      H_ADDR: begin
        bus.h_frame_n_o = 1'b0;
        bus.h_frame_oe_n = 1'b0;
        bus.h_ad_o = addr_r;
        bus.h_ad_oe_n = 1'b0;
        bus.h_cbe_o = wr_r ? CMD_MEM_WR : CMD_MEM_RD;
        bus.h_cbe_oe_n = 1'b0;
      end
      H_DATA: begin
        bus.h_frame_oe_n = 1'b0;
        bus.h_irdy_n_o = 1'b0;
        bus.h_irdy_oe_n = 1'b0;
        bus.h_cbe_o = be_r;
        bus.h_cbe_oe_n = 1'b0;
        bus.h_ad_o = wdata_r;
        bus.h_ad_oe_n = !wr_r;
      end
      H_TURN: bus.h_irdy_oe_n = 1'b0;
      H_T_DATA, H_T_STOP: begin
        bus.h_devsel_n_o = 1'b0;
        bus.h_devsel_oe_n = 1'b0;
        bus.h_trdy_n_o = retry_r | (state_r == H_T_STOP);
        bus.h_trdy_oe_n = 1'b0;
        bus.h_stop_n_o = (state_r == H_T_DATA) & !retry_r &
                         bus.frame_n;
        bus.h_stop_oe_n = 1'b0;
        bus.h_ad_o = t_rd_q_r;
        bus.h_ad_oe_n = t_wr_q_r | (state_r == H_T_STOP);
      end
      H_T_TURN: begin
        bus.h_devsel_oe_n = 1'b0;
        bus.h_trdy_oe_n = 1'b0;
        bus.h_stop_oe_n = 1'b0;
      end
      default: ;
    endcase
  end
endmodule

// ### test/pci_handshake_monitor.sv
`timescale 1ns/1ps
module pci_handshake_monitor
  import pci_pkg::*;
(
  input wire logic mclk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [AD_W-1:0] ad, // data
  input wire logic [CBE_W-1:0] cbe, // enables
  input wire logic par, // parity
  input wire logic frame_n, // frame
  input wire logic irdy_n, // initiator ready
  input wire logic trdy_n, // target ready
  input wire logic devsel_n, // claim
  input wire logic perr_n, // parity error
  input wire logic serr_n, // system error
  input wire logic req_n, // request
  input wire logic gnt_n, // grant
  input wire logic d_par_oe_n, // device drives par
  input wire logic d_frame_oe_n // device drives frame
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence xfer_end;
    !irdy_n && !trdy_n && frame_n;
  endsequence
  chk_par_even: assert property (
    !d_par_oe_n |-> par == ^{$past(ad), $past(cbe)}) else $error("par");
  chk_ready_claim: assert property (
    !trdy_n |-> !devsel_n) else $error("trdy unclaimed");
  chk_last_release: assert property (
    xfer_end |=> irdy_n && trdy_n) else $error("ready held");
  chk_grant_first: assert property (
    $fell(d_frame_oe_n) |-> !gnt_n || !$past(gnt_n)) else $error("gnt");
  chk_req_held: assert property (
    $rose(req_n) |-> !gnt_n || !$past(gnt_n)) else $error("req");
  chk_serr_pulse: assert property (
    $fell(serr_n) |=> serr_n) else $error("serr width");
  chk_serr_cause: assert property (
    !serr_n |-> !$past(frame_n, 2)) else $error("serr cause");
  chk_perr_pulse: assert property (
    $fell(perr_n) |=> perr_n) else $error("perr width");
endmodule

// ### test/pci_handshake_parity_errors_tb.sv
`timescale 1ns/1ps
module pci_handshake_parity_errors_tb;
  import pci_pkg::*;
  // ********
  // stimulus
  // ********
  logic mclk_i = 0, rst_i = 1, wake_i = 0, clr = 0, retry_i = 0;
  logic pc_card_select_strap_i = 1, clear_status_i = 0, par_flip_i = 0;
  logic m_start_i = 0, m_write_i = 0, h_start_i = 0, h_write_i = 0;
  logic [CMD_W-1:0] command_word_i = 16'h0140;
  logic [AD_W-1:0] m_addr_i = 0, m_wdata_i = 0, h_addr_i = 0, h_wdata_i = 0;
  logic [AD_W-1:0] t_rdata_i = 0, hrd = 0, m_rdata_o, h_rdata_o, t_addr_o;
  logic [AD_W-1:0] t_wdata_o, hta, htd, a;
  logic [CBE_W-1:0] m_be_i = 0, h_be_i = 0, t_be_o;
  logic m_busy_o, m_done_o, m_abort_o, m_stopped_o, t_wr_o, t_rd_o;
  logic h_busy_o, h_done_o, h_abort_o, h_stopped_o, htw, pe, se;
  logic [8:0] seen = 0;
  logic [1:0] errs = 0;
  logic [8:0] ex [6] = '{9'h028, 9'h018, 9'h101, 9'h100, 9'h040, 9'h004};
  int mismatches = 0, comparisons = 0, cyc = 0;
  pci_if bus ();
  pci_dev_end i_pci_dev_end (.mclk_i, .rst_i, .bus, .command_word_i,
    .pc_card_select_strap_i, .wake_i, .m_start_i, .m_write_i, .m_addr_i,
    .m_wdata_i, .m_be_i, .m_busy_o, .m_done_o, .m_abort_o, .m_stopped_o,
    .m_rdata_o, .t_wr_o, .t_rd_o, .t_addr_o, .t_wdata_o, .t_be_o,
    .t_rdata_i, .clear_status_i, .parity_error_seen_o(pe),
    .system_error_signaled_o(se));
  pci_host_end i_pci_host_end (.mclk_i, .rst_i, .bus, .h_start_i,
    .h_write_i, .h_addr_i, .h_wdata_i, .h_be_i, .h_busy_o, .h_done_o,
    .h_abort_o, .h_stopped_o, .h_rdata_o, .retry_i, .t_rdata_i(hrd),
    .par_flip_i, .t_wr_o(htw), .t_addr_o(hta), .t_wdata_o(htd));
  pci_handshake_monitor i_mon (.mclk_i, .rst_i, .ad(bus.ad), .cbe(bus.cbe),
    .par(bus.par), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n),
    .trdy_n(bus.trdy_n), .devsel_n(bus.devsel_n), .perr_n(bus.perr_n),
    .serr_n(bus.serr_n), .req_n(bus.req_n), .gnt_n(bus.gnt_n),
    .d_par_oe_n(bus.d_par_oe_n), .d_frame_oe_n(bus.d_frame_oe_n));
  initial forever #12.5 mclk_i = ~mclk_i;
  // pulses are one cycle wide, so they are gathered while an op runs
  always @(posedge mclk_i) begin
    seen <= clr ? 9'h0 : seen | {m_done_o, m_abort_o, m_stopped_o, t_wr_o,
      t_rd_o, h_done_o, h_abort_o, h_stopped_o, htw};
    errs <= clr ? 2'h0 : errs | {!bus.perr_n, !bus.serr_n};
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [63:0] s,
                     input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic op(input bit dm, input bit wr, input logic [AD_W-1:0] ad);
    int n = 0;
    {t_rdata_i, hrd, m_wdata_i} = {$urandom, $urandom, $urandom};
    {h_wdata_i, m_be_i, h_be_i} = {$urandom, 8'($urandom)};
    clr = 1;
    {m_start_i, m_write_i, m_addr_i} = {dm, wr, ad};
    {h_start_i, h_write_i, h_addr_i} = {!dm, wr, ad};
    @(posedge mclk_i);
    #2 {m_start_i, h_start_i, clr} = 3'h0;
    chk("busy", {m_busy_o, h_busy_o}, {dm, !dm});
    while (!(|(seen & 9'h1ce)) && n < 60) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (4) @(posedge mclk_i);
    #2;
  endtask
  // ********
  // scenarios
  // ********
  initial begin
    void'($urandom(32'h5eca0480));
    repeat (16) @(posedge mclk_i);
    #2 rst_i = 0;
    for (int i = 0; i < 6; i++) begin
      retry_i = (i == 4);
      a = i == 5 ? 32'h0002_0000 : 32'h0001_0000 | ($urandom & 32'hffc);
      op(i inside {[2:4]}, !i[0], a);
      chk("events", seen, ex[i]);
      if (i < 2) chk("t data", i ? h_rdata_o : t_wdata_o,
        i ? t_rdata_i : h_wdata_i);
      if (i == 0) chk("t addr", {t_addr_o, t_be_o}, {a, h_be_i});
      if (i == 2) chk("m write", {hta, htd}, {a, m_wdata_i});
      if (i == 3) chk("m read", m_rdata_o, hrd);
    end
    retry_i = 0;
    chk("status", {errs, pe, se}, 4'h0);
    par_flip_i = 1;
    op(0, 1, 32'h0001_0080);
    chk("bad par", {errs, pe, se}, 4'hf);
    clear_status_i = 1;
    @(posedge mclk_i);
    #2 clear_status_i = 0;
    chk("cleared", {pe, se}, 2'h0);
    command_word_i = 16'h0000;
    op(0, 1, 32'h0001_0080);
    par_flip_i = 0;
    chk("masked", {errs, pe, se}, 4'h2);
    wake_i = 1;
    repeat (3) @(posedge mclk_i);
    #2 chk("pme wake", bus.pme, 1'h0);
    rst_i = 1;
    pc_card_select_strap_i = 0;
    repeat (2) @(posedge mclk_i);
    #2 rst_i = 0;
    repeat (3) @(posedge mclk_i);
    #2 chk("card change", bus.pme, 1'h1);
    wake_i = 0;
    repeat (3) @(posedge mclk_i);
    #2 chk("card idle", bus.pme, 1'h0);
    op(1, 1, 32'h0001_0040);
    chk("after reset", seen, 9'h101);
    end_sim();
  end
endmodule
